/* File: logic/cam_encoder_dev.sv */
// Cam encoder device end: counter, cams, merge, pin mux, image.
`timescale 1ns/1ps
`default_nettype none
module cam_encoder_dev
    import cam_map_pkg::*;
#(
    parameter int TICK_1K = TICK_1K_CYC,     // Slowest internal tick
    parameter int TICK_10K = TICK_10K_CYC,   // 10 kHz tick
    parameter int TICK_100K = TICK_100K_CYC, // 100 kHz tick
    parameter int TICK_1M = TICK_1M_CYC      // 1 MHz tick
)(
    input wire logic sys_clk,             // System clock
    input wire logic reset,               // Async reset, active high
    input wire logic clk_en,              // Freezes all state when low
    cam_image_if.device img,              // Image shared with host
    input wire logic [7:0] in_pins,       // Input pins 1-8
    output logic [7:0] out_pins,          // Output pins 1-8
    output logic [1:0] threshold_sel,     // Input voltage threshold
    output logic [1:0] filter_sel,        // Input noise filter
    input wire logic [6:0] cfg_merge,     // Stored merge selection
    input wire logic cfg_marker_level,    // Stored active-low marker
    input wire logic cfg_marker_phase,    // Stored reversed phase
    input wire logic cfg_int_clock,       // Stored internal clock use
    input wire logic [1:0] cfg_prescale,  // Stored internal clock rate
    input wire logic [7:0] cfg_invert,    // Stored output negation
    input wire logic [1:0] cfg_threshold, // Stored threshold select
    input wire logic [1:0] cfg_filter     // Stored filter select
);
    // Refuse tick periods the divider cannot hold
    if (TICK_1K < 1 || TICK_1K >= (1 << DIV_W) || TICK_10K < 1 ||
        TICK_100K < 1 || TICK_1M < 1)
    begin : g_chk
        $error("tick periods out of range");
    end

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [DIV_W-1:0] div;
        logic a_q;
        logic b_q;
        logic [7:0] pins;
        logic [1:0] thr;
        logic [1:0] flt;
        logic [15:0] cnt_lo;
        logic [15:0] cnt_hi;
    } dev_state_t;

    dev_state_t st_q;
    dev_state_t st_d;

    // Effective controls after the override choice
    logic ovr;
    logic [6:0] merge_sel;
    logic marker_level;
    logic marker_phase;
    logic int_clock;
    logic [1:0] prescale;
    logic [7:0] invert;
    logic [1:0] thr_eff;
    logic [1:0] flt_eff;
    logic count_clear;
    logic [CNT_W-1:0] cpr_last;
    logic [31:0] cpr;
    logic [CAM_N-1:0] cam;
    logic [CAM_N-1:0] joined;
    logic [DIV_W-1:0] tick_last;

    assign ovr = img.dq[Q_MASK];

    // Stored configuration unless the host asserts the override bit;
    // the host's override bits are otherwise simply not looked at
    always_comb
    begin
        if (ovr) // R3
        begin
            merge_sel = img.dq[Q_MRG0 +: 7];
            marker_level = img.dq[Q_MKLVL];
            marker_phase = img.dq[Q_MKPHS];
            int_clock = img.dq[Q_ICLK];
            prescale = img.dq[Q_PRE0 +: 2];
            invert = img.dq[Q_INV0 +: 8];
            thr_eff = img.dq[Q_VIN0 +: 2];
            flt_eff = img.dq[Q_FRQ0 +: 2];
            count_clear = img.dq[Q_CRST];
        end
        else // R2
        begin
            merge_sel = cfg_merge;
            marker_level = cfg_marker_level;
            marker_phase = cfg_marker_phase;
            int_clock = cfg_int_clock;
            prescale = cfg_prescale;
            invert = cfg_invert;
            thr_eff = cfg_threshold;
            flt_eff = cfg_filter;
            count_clear = 1'b0;
        end
    end

    // Counts per revolution, low word first; zero means full range
    assign cpr = {img.aq[AQ_CPR + 1], img.aq[AQ_CPR]}; // R15
    assign cpr_last = (cpr == 32'h0000_0000 || cpr > (32'h1 << CNT_W))
                      ? {CNT_W{1'b1}} : CNT_W'(cpr - 32'h1);

    // Internal clock period for the selected rate
    always_comb
    begin
        case (prescale) // R8
            2'b00: tick_last = DIV_W'(TICK_1M - 1);
            2'b01: tick_last = DIV_W'(TICK_100K - 1);
            2'b10: tick_last = DIV_W'(TICK_10K - 1);
            default: tick_last = DIV_W'(TICK_1K - 1);
        endcase
    end

    // One window per cam channel
    for (genvar i = 0; i < CAM_N; i++)
    begin : g_cam
        cam_window u_win (
            .count(st_q.count),
            .low_sp({img.aq[AQ_CAM0 + 4*i + 1], img.aq[AQ_CAM0 + 4*i]}),
            .high_sp({img.aq[AQ_CAM0 + 4*i + 3], img.aq[AQ_CAM0 + 4*i + 2]}),
            .invert(invert[i]),
            .active(cam[i])
        );
    end

    // Merge tree: each joined cam feeds a higher one, so walking upward
    // in one pass collects chains such as 1 into 2 into 4 into 8
    always_comb
    begin
        joined = cam;
        for (int j = 0; j < CAM_N - 1; j++)
        begin
            if (merge_sel[j])
            begin
                joined[MERGE_TO[j]] = joined[MERGE_TO[j]] | joined[j]; // R6
            end
        end
    end

    // Next state
    always_comb
    begin
        logic up;
        logic down;
        logic tick;
        logic marker;
        up = 1'b0;
        down = 1'b0;
        tick = 1'b0;
        marker = 1'b0;
        st_d = st_q;
        st_d.a_q = in_pins[PIN_A];
        st_d.b_q = in_pins[PIN_B];
        // Internal tick divider runs only while selected
        if (int_clock)
        begin
            if (st_q.div >= tick_last)
            begin
                st_d.div = '0;
                tick = 1'b1;
            end
            else
            begin
                st_d.div = st_q.div + DIV_W'(1);
            end
        end
        else
        begin
            st_d.div = '0;
        end
        // Internal clock forces up counting; otherwise x4 quadrature
        if (int_clock)
        begin
            up = tick;
        end
        else
        begin
            up = (in_pins[PIN_A] ^ st_q.b_q) & ~(in_pins[PIN_B] ^ st_q.a_q);
            down = (in_pins[PIN_B] ^ st_q.a_q) & ~(in_pins[PIN_A] ^ st_q.b_q);
        end
        // Marker level and phase conditioning, gated by its disable pin
        marker = (in_pins[PIN_M] ^ marker_level) &
                 (in_pins[PIN_B] ^ marker_phase) &
                 ~in_pins[PIN_MDIS]; // R9
        if (count_clear || marker)
        begin
            st_d.count = '0;
        end
        else if (up)
        begin
            st_d.count = (st_q.count >= cpr_last) ? '0
                         : st_q.count + CNT_W'(1);
        end
        else if (down)
        begin
            st_d.count = (st_q.count == '0) ? cpr_last
                         : st_q.count - CNT_W'(1);
        end
        // Pins 1-7 carry their cam unless it was merged away, then the
        // host's general purpose bit; pin 8 always carries cam 8
        for (int k = 0; k < CAM_N - 1; k++)
        begin
            st_d.pins[k] = merge_sel[k] ? img.dq[Q_GP0 + k] : joined[k]; // R5
        end
        st_d.pins[CAM_N-1] = joined[CAM_N-1]; // R5
        st_d.thr = thr_eff; // R10
        st_d.flt = flt_eff; // R10
        // Snapshot of the count split into two words
        st_d.cnt_lo = st_q.count[15:0]; // R15
        st_d.cnt_hi = {8'h00, st_q.count[CNT_W-1:16]}; // R15
    end

    // State register with clock enable
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
        end
    end

    // Image back to the host; unused output bits are never read
    assign img.di[I_PIN0 +: 8] = in_pins; // R13
    assign img.di[I_OUT0 +: 8] = st_q.pins; // R13
    assign img.ai[AI_OPT] = OPTION_NUMBER; // R11
    assign img.ai[AI_CNT_LO] = st_q.cnt_lo; // R11
    assign img.ai[AI_CNT_HI] = st_q.cnt_hi; // R11
    assign out_pins = st_q.pins;
    assign threshold_sel = st_q.thr;
    assign filter_sel = st_q.flt;
    // Positions 16, 21-24 and 39-40 of the output image are left
    // unconnected on purpose
    // R4
endmodule
`default_nettype wire

/* File: logic/cam_map_pkg.sv */
// Shared constants and types for the cam encoder image.
//
// Contract
// R1 - Host writes zero to unset parameter blocks
// R2 - Override bit 0: stored configuration, host ignored
// R3 - Override bit 1: host values replace stored
// R4 - Unused image positions have no behaviour
// R5 - Combined cams appear on highest-numbered output
// R6 - Cams combine for several events per revolution
// R7 - Inversion swaps on and off set-points
// R8 - Internal clock at 1M, 100k, 10k, 1k
// R9 - Marker active-low and reversed-phase options
// R10 - Selectable input threshold and noise filter
// R11 - Image: 16 in, 40 out, 3+34 words
// R12 - Host adds starting location to each index
// R13 - Inputs 1-8 pins, 9-16 output states
// R14 - Cam active between low and high set-points
// R15 - 32-bit values: low word, then high word
`default_nettype none
package cam_map_pkg;
    // Image sizes
    localparam int DI_N = 16;
    localparam int DQ_N = 40;
    localparam int AI_N = 3;
    localparam int AQ_N = 34;
    localparam int CAM_N = 8;
    localparam int CNT_W = 24;
    // Discrete output bit positions, zero based
    localparam int Q_GP0 = 0;
    localparam int Q_MASK = 7;
    localparam int Q_MRG0 = 8;
    localparam int Q_MKLVL = 16;
    localparam int Q_MKPHS = 17;
    localparam int Q_ICLK = 18;
    localparam int Q_CRST = 19;
    localparam int Q_INV0 = 24;
    localparam int Q_VIN0 = 32;
    localparam int Q_FRQ0 = 34;
    localparam int Q_PRE0 = 36;
    // Discrete input positions
    localparam int I_PIN0 = 0;
    localparam int I_OUT0 = 8;
    // Input pin roles
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_M = 2;
    localparam int PIN_MDIS = 3;
    // Word positions, zero based
    localparam int AI_OPT = 0;
    localparam int AI_CNT_LO = 1;
    localparam int AI_CNT_HI = 2;
    localparam int AQ_CAM0 = 0;
    localparam int AQ_CPR = 32;
    localparam logic [15:0] OPTION_NUMBER = 16'h0003;
    // Merge destination of cams 1..7 (zero based), cam 8 has none
    localparam int MERGE_TO [0:6] = '{1, 3, 3, 7, 5, 7, 7};
    // Internal clock periods and their cycle counts at 200 MHz
    localparam int CLK_NS = 5;
    localparam int TICK_1M_NS = 1000;
    localparam int TICK_100K_NS = 10000;
    localparam int TICK_10K_NS = 100000;
    localparam int TICK_1K_NS = 1000000;
    localparam int TICK_1M_CYC = TICK_1M_NS / CLK_NS;
    localparam int TICK_100K_CYC = TICK_100K_NS / CLK_NS;
    localparam int TICK_10K_CYC = TICK_10K_NS / CLK_NS;
    localparam int TICK_1K_CYC = TICK_1K_NS / CLK_NS;
    localparam int DIV_W = 18;
    // Host write and read kinds
    typedef enum logic [1:0] {K_DISC_IN, K_DISC_OUT, K_WORD_IN, K_WORD_OUT}
        img_kind_t;
endpackage
`default_nettype wire

/* File: logic/cam_image_if.sv */
// Shared I/O image between the host and the cam encoder.
`timescale 1ns/1ps
`default_nettype none
interface cam_image_if;
    import cam_map_pkg::*;
    logic [DI_N-1:0] di;              // Discrete inputs, device to host
    logic [DQ_N-1:0] dq;              // Discrete outputs, host to device
    logic [AI_N-1:0][15:0] ai;        // Input words, device to host
    logic [AQ_N-1:0][15:0] aq;        // Output words, host to device
    modport device (input dq, input aq, output di, output ai);
    modport host (output dq, output aq, input di, input ai);
endinterface
`default_nettype wire

/* File: logic/cam_window.sv */
// One cam channel: range compare with optional inversion.
`timescale 1ns/1ps
`default_nettype none
module cam_window
    import cam_map_pkg::*;
(
    input wire logic [CNT_W-1:0] count, // Current position
    input wire logic [31:0] low_sp,     // Low set-point
    input wire logic [31:0] high_sp,    // High set-point
    input wire logic invert,            // Negated polarity
    output logic active                 // Cam signal
);
    logic in_range;
    // Inclusive window; a high set-point beyond the revolution is never
    // reached, so the revolution end bounds it naturally
    assign in_range = ({8'h00, count} >= low_sp) &&
                      ({8'h00, count} <= high_sp); // R14
    // Negation swaps the roles of the two set-points
    assign active = in_range ^ invert; // R7
endmodule
`default_nettype wire

/* File: logic/cam_host_end.sv */
// Host end: holds the output image, serves absolute-index access.
`timescale 1ns/1ps
`default_nettype none
module cam_host_end
    import cam_map_pkg::*;
#(
    parameter int BASE_I = 1,  // Starting location of discrete inputs
    parameter int BASE_Q = 1,  // Starting location of discrete outputs
    parameter int BASE_AI = 1, // Starting location of input words
    parameter int BASE_AQ = 1  // Starting location of output words
)(
    input wire logic sys_clk,          // System clock
    input wire logic reset,            // Async reset, active high
    input wire logic clk_en,           // Freezes all state when low
    cam_image_if.host img,             // Image shared with device
    input wire logic wr_en,            // Write strobe
    input wire img_kind_t wr_kind,     // Image area written
    input wire logic [15:0] wr_index,  // Absolute index
    input wire logic [15:0] wr_data,   // Word, or bit 0 for a bit
    input wire logic rd_en,            // Read strobe
    input wire img_kind_t rd_kind,     // Image area read
    input wire logic [15:0] rd_index,  // Absolute index
    output logic [15:0] rd_data,       // Read result
    output logic rd_valid              // Read result pulse
);
    if (BASE_I < 0 || BASE_Q < 0 || BASE_AI < 0 || BASE_AQ < 0)
    begin : g_chk
        $error("starting locations must not be negative");
    end

    typedef struct packed {
        logic [DQ_N-1:0] dq;
        logic [AQ_N-1:0][15:0] aq;
        logic [15:0] rd_data;
        logic rd_valid;
    } host_state_t;

    host_state_t st_q;
    host_state_t st_d;

    // Relative index from absolute; out of range reads zero, writes drop
    function automatic int rel(input logic [15:0] idx, input int base);
        return int'(idx) - base;
    endfunction

    always_comb
    begin
        int w;
        int r;
        w = 0;
        r = 0;
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        if (wr_en)
        begin
            if (wr_kind == K_DISC_OUT)
            begin
                w = rel(wr_index, BASE_Q); // R12
                if (w >= 0 && w < DQ_N)
                begin
                    st_d.dq[w] = wr_data[0];
                end
            end
            else if (wr_kind == K_WORD_OUT)
            begin
                w = rel(wr_index, BASE_AQ); // R12
                if (w >= 0 && w < AQ_N)
                begin
                    st_d.aq[w] = wr_data;
                end
            end
        end
        if (rd_en)
        begin
            st_d.rd_valid = 1'b1;
            st_d.rd_data = '0;
            case (rd_kind)
                K_DISC_IN:
                begin
                    r = rel(rd_index, BASE_I); // R12
                    if (r >= 0 && r < DI_N)
                        st_d.rd_data = {15'h0000, img.di[r]};
                end
                K_DISC_OUT:
                begin
                    r = rel(rd_index, BASE_Q);
                    if (r >= 0 && r < DQ_N)
                        st_d.rd_data = {15'h0000, st_q.dq[r]};
                end
                K_WORD_IN:
                begin
                    r = rel(rd_index, BASE_AI);
                    if (r >= 0 && r < AI_N)
                        st_d.rd_data = img.ai[r];
                end
                default:
                begin
                    r = rel(rd_index, BASE_AQ);
                    if (r >= 0 && r < AQ_N)
                        st_d.rd_data = st_q.aq[r];
                end
            endcase
        end
    end

    // Blocks the user never sets stay at zero from reset
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '0; // R1
        end
        else if (clk_en)
        begin
            st_q <= st_d;
        end
    end

    assign img.dq = st_q.dq; // R11
    assign img.aq = st_q.aq; // R11
    assign rd_data = st_q.rd_data;
    assign rd_valid = st_q.rd_valid;
endmodule
`default_nettype wire

/* File: verification/cam_image_assertions.sv */
// Concurrent checks on the image link between host end and cam encoder.
`timescale 1ns/1ps
`default_nettype none
module cam_image_assertions
    import cam_map_pkg::*;
(
    input wire logic sys_clk,               // System clock
    input wire logic reset,                 // Async reset, active high
    input wire logic clk_en,                // Run enable
    input wire logic [DI_N-1:0] di,         // Discrete inputs
    input wire logic [DQ_N-1:0] dq,         // Discrete outputs
    input wire logic [AI_N-1:0][15:0] ai,   // Input words
    input wire logic [7:0] in_pins,         // Input pins
    input wire logic [7:0] out_pins,        // Output pins
    input wire logic [1:0] threshold_sel,   // Threshold in use
    input wire logic [1:0] filter_sel,      // Filter in use
    input wire logic [1:0] cfg_threshold,   // Stored threshold
    input wire logic [1:0] cfg_filter       // Stored filter
);
    // One clock domain, so clock and disable are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_opt;
        ai[AI_OPT] == OPTION_NUMBER;
    endproperty
    a_opt: assert property (p_opt) else $error("option word wrong");
    property p_pins;
        di[7:0] == in_pins;
    endproperty
    a_pins: assert property (p_pins) else $error("pin image wrong");
    // Output image and pins come from the same register stage
    property p_outs;
        di[15:8] == out_pins;
    endproperty
    a_outs: assert property (p_outs) else $error("out image wrong");
    property p_cnt_top;
        ai[AI_CNT_HI][15:8] == 8'h00;
    endproperty
    a_cnt_top: assert property (p_cnt_top) else $error("count top");
    // A low enable must hold every input word and output state seen by the host
    property p_hold;
        !clk_en |=> $stable(ai) && $stable(di[15:8]);
    endproperty
    a_hold: assert property (p_hold) else $error("not frozen");
    property p_thr_cfg;
        clk_en && !dq[Q_MASK] |=> threshold_sel == $past(cfg_threshold);
    endproperty
    a_thr_cfg: assert property (p_thr_cfg) else $error("thr cfg");
    property p_thr_ovr;
        clk_en && dq[Q_MASK] |=> threshold_sel == $past(dq[Q_VIN0+1:Q_VIN0]);
    endproperty
    a_thr_ovr: assert property (p_thr_ovr) else $error("thr host");
    property p_flt_cfg;
        clk_en && !dq[Q_MASK] |=> filter_sel == $past(cfg_filter);
    endproperty
    a_flt_cfg: assert property (p_flt_cfg) else $error("flt cfg");
    property p_flt_ovr;
        clk_en && dq[Q_MASK] |=> filter_sel == $past(dq[Q_FRQ0+1:Q_FRQ0]);
    endproperty
    a_flt_ovr: assert property (p_flt_ovr) else $error("flt host");
    property p_clr;
        clk_en && dq[Q_MASK] && dq[Q_CRST] ##1 clk_en
            |=> ai[AI_CNT_LO] == 16'h0000 && ai[AI_CNT_HI] == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench joining host end and cam encoder end.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cam_map_pkg::*;
    localparam int BI = 10;
    localparam int BQ = 3;
    localparam int BAI = 20;
    localparam int BAQ = 7;
    localparam int CPR = 40; // Short revolution keeps the run brief
    localparam int TK [0:3] = '{5, 10, 15, 20};
    localparam logic [1:0] GRAY [0:3] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    img_kind_t wr_kind = K_DISC_IN;
    img_kind_t rd_kind = K_DISC_IN;
    logic [15:0] wr_index = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_index = 16'h0000;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [7:0] in_pins = 8'h08; // Marker disabled by default
    logic [7:0] out_pins;
    logic [1:0] threshold_sel;
    logic [1:0] filter_sel;
    logic [6:0] cfg_merge = 7'h00;
    logic cfg_marker_level = 1'b0;
    logic cfg_marker_phase = 1'b0;
    logic [1:0] cfg_threshold = 2'h0;
    logic [1:0] cfg_filter = 2'h0;
    logic [7:0] cfg_invert = 8'h00;
    logic [31:0] seed = 32'h341a;
    int n_fail = 0;
    int n_tests = 0;
    int cnt = 0;
    int qs = 0;
    logic [31:0] lo [8];
    logic [31:0] hi [8];
    logic [15:0] w;
    logic [15:0] w2;
    logic [39:0] dqv;
    logic [6:0] mg;
    logic [7:0] iv;
    logic [7:0] pe;
    cam_image_if link();
    cam_host_end #(.BASE_I(BI), .BASE_Q(BQ), .BASE_AI(BAI), .BASE_AQ(BAQ))
    i_cam_host_end (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .img(link), .wr_en(wr_en), .wr_kind(wr_kind), .wr_index(wr_index),
        .wr_data(wr_data), .rd_en(rd_en), .rd_kind(rd_kind),
        .rd_index(rd_index), .rd_data(rd_data), .rd_valid(rd_valid));
    cam_encoder_dev #(.TICK_1M(TK[0]), .TICK_100K(TK[1]), .TICK_10K(TK[2]),
        .TICK_1K(TK[3]))
    i_cam_encoder_dev (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .img(link), .in_pins(in_pins), .out_pins(out_pins),
        .threshold_sel(threshold_sel), .filter_sel(filter_sel),
        .cfg_merge(cfg_merge), .cfg_marker_level(cfg_marker_level),
        .cfg_marker_phase(cfg_marker_phase), .cfg_int_clock(1'b0),
        .cfg_prescale(2'h0), .cfg_invert(cfg_invert),
        .cfg_threshold(cfg_threshold), .cfg_filter(cfg_filter));
    cam_image_assertions i_cam_image_assertions (.sys_clk(sys_clk),
        .reset(reset), .clk_en(clk_en), .di(link.di), .dq(link.dq),
        .ai(link.ai), .in_pins(in_pins), .out_pins(out_pins),
        .threshold_sel(threshold_sel), .filter_sel(filter_sel),
        .cfg_threshold(cfg_threshold), .cfg_filter(cfg_filter));
    // Free-running 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Cams fold along the merge chain; vacated pins carry gp bits
    function automatic logic [7:0] pin_exp(logic [6:0] m, logic [7:0] v,
        logic [6:0] gp);
        logic [7:0] p;
        int d;
        p = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            d = i;
            while (d < 7 && m[d])
                d = MERGE_TO[d];
            if ((lo[i] <= cnt && cnt <= hi[i]) ^ v[i])
                p[d] = 1'b1;
        end
        for (int i = 0; i < 7; i++)
            if (m[i])
                p[i] = gp[i];
        return p;
    endfunction
    task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pins(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(img_kind_t k, int idx, logic [15:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        wr_kind <= k;
        wr_index <= 16'(idx);
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    // Result stands one cycle, so it is sampled just after the edge
    task automatic rd(img_kind_t k, int idx, output logic [15:0] d);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        rd_kind <= k;
        rd_index <= 16'(idx);
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk_word("rd_valid", 16'h0001, {15'h0000, rd_valid});
        d = rd_data;
    endtask
    task automatic wr32(int idx, logic [31:0] v);
        wr(K_WORD_OUT, idx, v[15:0]);
        wr(K_WORD_OUT, idx + 1, v[31:16]);
    endtask
    task automatic set_dq(logic [39:0] v);
        for (int i = 0; i < DQ_N; i++)
            wr(K_DISC_OUT, BQ + i, {15'h0000, v[i]});
    endtask
    task automatic step(int dir);
        qs = (qs + dir + 4) % 4;
        cnt = (cnt + dir + CPR) % CPR;
        @(posedge sys_clk);
        in_pins[1:0] <= GRAY[qs];
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, about five times the expected run length
    initial
    begin
        #100000;
        n_fail++;
        results();
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(K_WORD_IN, BAI + AI_OPT, w);
        chk_word("option", OPTION_NUMBER, w);
        wr(K_WORD_IN, BAI + AI_OPT, 16'h5a5a);
        rd(K_WORD_IN, BAI + AI_OPT, w);
        chk_word("option_kept", OPTION_NUMBER, w);
        rd(K_WORD_IN, BAI + AI_N, w);
        chk_word("beyond_words", 16'h0000, w);
        w = 16'(rnd());
        @(posedge sys_clk);
        in_pins[7:4] <= w[3:0];
        for (int j = 0; j < 8; j++)
        begin
            rd(K_DISC_IN, BI + j, w);
            chk_word("pin_in", {15'h0000, in_pins[j]}, w);
        end
        wr32(BAQ + AQ_CPR, CPR);
        step(-1);
        rd(K_WORD_IN, BAI + AI_CNT_LO, w);
        chk_word("wrap_low", 16'(CPR - 1), w);
        rd(K_WORD_IN, BAI + AI_CNT_HI, w);
        chk_word("wrap_high", 16'h0000, w);
        // Fixed and random merge sets, with random polarity and alternating override
        for (int j = 0; j < 6; j++)
        begin
            mg = (j == 0) ? 7'h00 : (j == 1) ? 7'h7f : 7'(rnd());
            iv = 8'(rnd());
            dqv = 40'({rnd(), rnd()});
            dqv[Q_MASK] = j[0];
            dqv[Q_ICLK] = 1'b0;
            dqv[Q_CRST] = 1'b0;
            dqv[Q_MRG0 +: 7] = j[0] ? mg : ~mg;
            dqv[Q_INV0 +: 8] = j[0] ? iv : ~iv;
            w = 16'(rnd());
            @(posedge sys_clk);
            cfg_merge <= j[0] ? ~mg : mg;
            cfg_invert <= j[0] ? ~iv : iv;
            cfg_threshold <= w[1:0];
            cfg_filter <= w[3:2];
            cfg_marker_level <= w[4];
            cfg_marker_phase <= w[5];
            for (int k = 0; k < 8; k++)
            begin
                lo[k] = rnd() % CPR;
                hi[k] = (k == j) ? 32'h0001_0000 : lo[k] + rnd() % 8;
                wr32(BAQ + 4 * k, lo[k]);
                wr32(BAQ + 4 * k + 2, hi[k]);
            end
            set_dq(dqv);
            for (int s = 0; s < CPR; s++)
            begin
                step(1);
                repeat (2) @(posedge sys_clk);
                #1;
                pe = pin_exp(mg, iv, dqv[6:0]);
                chk_pins("cam_pins", pe, out_pins);
            end
        end
        // Internal tick rate for every prescale code
        for (int p = 0; p < 4; p++)
        begin
            dqv = 40'h0;
            dqv[Q_MASK] = 1'b1;
            dqv[Q_ICLK] = 1'b1;
            dqv[Q_PRE0 +: 2] = 2'(p);
            set_dq(dqv);
            rd(K_WORD_IN, BAI + AI_CNT_LO, w);
            repeat (10 * TK[p] - 2) @(posedge sys_clk);
            rd(K_WORD_IN, BAI + AI_CNT_LO, w2);
            chk_word("tick_rate", 16'h000a, 16'((w2 + CPR - w) % CPR));
        end
        // Enable low while the internal clock runs; the hold check
        // watches that nothing moves
        clk_en <= 1'b0;
        repeat (40) @(posedge sys_clk);
        clk_en <= 1'b1;
        dqv[Q_CRST] = 1'b1;
        set_dq(dqv);
        rd(K_WORD_IN, BAI + AI_CNT_LO, w);
        chk_word("cleared", 16'h0000, w);
        dqv = 40'h0;
        dqv[Q_MASK] = 1'b1;
        set_dq(dqv);
        cnt = 0;
        // Marker level, phase and disable; B stays where the steps left it
        for (int c = 0; c < 8; c++)
        begin
            dqv[Q_MKLVL] = c[0];
            dqv[Q_MKPHS] = c[1];
            set_dq(dqv);
            for (int s = 0; s < 4; s++)
                step(1);
            in_pins[2] <= ~c[0];
            in_pins[3] <= c[2];
            repeat (4) @(posedge sys_clk);
            rd(K_WORD_IN, BAI + AI_CNT_LO, w);
            if ((GRAY[qs][1] ^ c[1]) && !c[2])
                cnt = 0;
            chk_word("marker", 16'(cnt), w);
            @(posedge sys_clk);
            in_pins[3] <= 1'b1;
        end
        results();
    end
endmodule
`default_nettype wire
